// ==== dv/zcl_analog_model.sv ====
// Model of the analog sink and source stage.
`timescale 1ns/1ps
module zcl_analog_model
(
	input wire logic clock,
	input wire logic want,
	output logic     sink_active
);
	always @(posedge clock) sink_active <= want;
endmodule

// ==== dv/zcl_props.sv ====
// Checker for bus answers and interrupt routing of the zero-cross block.
`timescale 1ns/1ps
module zcl_props
(
	input wire logic        clock,
	input wire logic        reset_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [31:0] prdata,
	input wire logic        cross_logic_out,
	input wire logic        irq,
	input wire logic        irq_high,
	input wire logic        irq_low
);
	logic        s1;
	logic        w1;
	logic        w2;
	logic        w3;
	logic [11:0] a1;
	always_ff @(posedge clock)
	begin
		s1 <= psel && !penable;
		w1 <= psel && !penable && pwrite;
		w2 <= w1;
		w3 <= w2;
		a1 <= paddr;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	ready_follow_a: assert property (psel && !penable |=> pready) else $error("no ready");
	ready_cause_a: assert property (pready |-> s1) else $error("stray ready");
	err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
	err_map_a: assert property (psel && !penable && paddr > 12'h010 |=> pslverr) else $error("no error");
	err_data_a: assert property (pslverr |-> prdata == 32'h0) else $error("error data");
	clr_read_a: assert property (pready && !w1 && a1 == zcl_pkg::ADDR_IRQ_CLR |-> prdata == 32'h0) else $error("clear read");
	route_one_a: assert property (irq |-> irq_high != irq_low) else $error("bad route");
	route_idle_a: assert property (!irq |-> !irq_high && !irq_low) else $error("idle route");
	irq_hold_a: assert property ($fell(irq) |-> w3) else $error("irq dropped");
	cover property (irq_low);
	cover property (pslverr);
	cover property ($rose(cross_logic_out));
endmodule
bind zcl_top zcl_props i_props(.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr), .prdata(prdata),
	.cross_logic_out(cross_logic_out), .irq(irq), .irq_high(irq_high), .irq_low(irq_low));

// ==== dv/zero_cross_logic_output_irq_test.sv ====
// Testbench of the zero-cross block.
`timescale 1ns/1ps
module test_zero_cross_logic_output_irq;
	logic clock, reset_n, want, sink_active, psel, penable, pwrite, pready, pslverr, clo, irq, ih, il, e, p, nv, o;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [1:0]  en;
	int          n_fail, checks_done, cycles, i;
	zcl_analog_model i_ana(.clock(clock), .want(want), .sink_active(sink_active));
	zcl_top i_dut(.clock(clock), .reset_n(reset_n), .sink_active(sink_active), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.cross_logic_out(clo), .irq(irq), .irq_high(ih), .irq_low(il));
	always #20 clock = ~clock;
	function automatic logic ef(input logic a, b, input logic [1:0] m);
		return (!a && b && m[0]) || (a && !b && m[1]);
	endfunction
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clock) penable <= 1;
		do @(posedge clock); while (pready !== 1'b1);
		r = prdata; e = pslverr;
		psel <= 0; penable <= 0;
		@(posedge clock);
	endtask
	task automatic chk(input string n, input logic [31:0] x, g);
		checks_done++;
		if (g !== x)
		begin
			n_fail++;
			$display("Error %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			n_fail++;
			wrap_up;
		end
	end
	initial
	begin
		clock = 0; reset_n = 0; want = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
		void'($urandom(89));
		repeat (8) @(posedge clock);
		reset_n <= 1;
		repeat (2) @(posedge clock);
		chk("irq", 0, irq);
		apb(1, zcl_pkg::ADDR_IRQ_EN, 1);
		apb(1, zcl_pkg::ADDR_SYSTEM, 32'h6);
		for (i = 0; i < 24; i++)
		begin
			p = $urandom; en = $urandom; nv = $urandom; o = want ^ p;
			apb(1, zcl_pkg::ADDR_CONTROL, {en, p});
			repeat (4) @(posedge clock);
			apb(1, zcl_pkg::ADDR_IRQ_CLR, 1);
			want <= nv;
			repeat (5) @(posedge clock);
			apb(0, zcl_pkg::ADDR_STATUS, 0);
			chk("status", {nv ^ p, ef(o, nv ^ p, en)}, r[1:0]);
			chk("out", nv ^ p, clo);
			chk("irq", ef(o, nv ^ p, en), irq);
		end
		$display("edge test done");
		apb(1, zcl_pkg::ADDR_IRQ_CLR, 1);
		apb(1, zcl_pkg::ADDR_CONTROL, {3'h0, ~p});
		apb(0, zcl_pkg::ADDR_STATUS, 0);
		chk("pol flag", 1, r[0]);
		apb(1, zcl_pkg::ADDR_CONTROL, {3'h3, ~p});
		apb(1, zcl_pkg::ADDR_IRQ_CLR, 1);
		apb(0, zcl_pkg::ADDR_STATUS, 0);
		chk("clear", 0, r[0]);
		want <= ~want;
		repeat (2) @(posedge clock);
		apb(1, zcl_pkg::ADDR_IRQ_CLR, 1);
		apb(0, zcl_pkg::ADDR_STATUS, 0);
		chk("set wins", 1, r[0]);
		for (i = 0; i < 4; i++)
		begin
			apb(1, zcl_pkg::ADDR_SYSTEM, {27'h0, i[1:0], 3'h6});
			repeat (2) @(posedge clock);
			chk("route", {!i[0] || i[1], i[0] && !i[1]}, {ih, il});
		end
		apb(0, 12'h014, 0);
		chk("unmapped", 1, e);
		$display("register test done");
		wrap_up;
	end
endmodule

// ==== hw/zcl_pkg.sv ====
// Package with register map, field positions and reset values of the zero-cross logic block.
package zcl_pkg;

	localparam logic [11:0] ADDR_CONTROL  = 12'h000;
	localparam logic [11:0] ADDR_STATUS   = 12'h004;
	localparam logic [11:0] ADDR_IRQ_EN   = 12'h008;
	localparam logic [11:0] ADDR_IRQ_CLR  = 12'h00C;
	localparam logic [11:0] ADDR_SYSTEM   = 12'h010;

	localparam int CTRL_POL_BIT      = 0;
	localparam int CTRL_RISE_EN_BIT  = 1;
	localparam int CTRL_FALL_EN_BIT  = 2;
	localparam int CTRL_SENSOR_BIT   = 3;

	localparam int STAT_FLAG_BIT     = 0;
	localparam int STAT_OUT_BIT      = 1;

	localparam int SYS_IE_BIT        = 0;
	localparam int SYS_GROUP_BIT     = 1;
	localparam int SYS_GLOBAL_BIT    = 2;
	localparam int SYS_LEVELS_BIT    = 3;
	localparam int SYS_PRIO_BIT      = 4;

	localparam logic [3:0] CTRL_RESET = 4'h0;
	localparam logic [0:0] IRQ_EN_RESET = 1'h0;
	localparam logic [4:0] SYS_RESET  = 5'h00;

	typedef enum logic [1:0]
	{
		ZCL_SETUP  = 2'h1,
		ZCL_ACCESS = 2'h2
	} zcl_apb_t;

	typedef struct packed
	{
		logic [1:0]  sync;
		logic        prev_out;
		logic        out_valid;
		logic        cross_logic_out;
		logic [3:0]  cross_control_reg;
		logic        cross_irq_flag;
		logic        irq_line_enable;
		logic [4:0]  system_bits;
		logic        irq_out;
		logic        irq_high;
		logic        irq_low;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} zcl_state_t;

endpackage

// ==== hw/zcl_top.sv ====
// Zero-cross detector digital back end: polarity, edge detect, interrupt flag and APB registers.
//
// How it works
// - With inversion off the logic output is high while the sink is active, low while the source is, and is readable.
// - Setting the polarity bit inverts the logic output.
// - The polarity-adjusted output is driven out for use as timer gate, clock and reset source.
// - Separate rising and falling edge detectors watch the logic output.
// - The flag is set when a detector fires and its own enable bit is set.
// - Edges are taken after polarity inversion.
// - With priority levels on, the interrupt goes out high or low priority per its priority bit.
// - A processor interrupt needs line enable, group enable, global enable and an edge enable all set.
// - Any write that changes the polarity bit sets the flag, whatever the sensor enable.
// - A qualifying edge in the clearing cycle wins, leaving the flag set.
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps

module zcl_top
(
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire logic        sink_active,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic             pslverr,
	output logic [31:0]      prdata,
	output logic             cross_logic_out,
	output logic             irq,
	output logic             irq_high,
	output logic             irq_low
);

	zcl_pkg::zcl_state_t state;
	zcl_pkg::zcl_state_t next_state;

	logic setup_cycle;
	logic access_done;
	logic wr_strobe;
	logic rd_strobe;
	logic wr_control;
	logic wr_clear;
	logic mapped;
	logic pol_bit;
	logic rise_en;
	logic fall_en;
	logic any_edge_en;
	logic line_en;
	logic group_en;
	logic global_en;
	logic levels_en;
	logic prio_bit;
	logic next_out;
	logic rise_hit;
	logic fall_hit;
	logic pol_change;
	logic set_flag;
	logic clr_flag;
	logic request;
	logic route_high;
	logic route_low;

	// A write lands only at the edge where the access phase sees pready, never at setup.
	always_comb
	begin
		setup_cycle = psel && !penable;
		access_done = psel && penable && state.pready;
		wr_strobe = access_done && pwrite;
		rd_strobe = setup_cycle && !pwrite;
		wr_control = wr_strobe && (paddr == zcl_pkg::ADDR_CONTROL);
		wr_clear = wr_strobe && (paddr == zcl_pkg::ADDR_IRQ_CLR);
	end

	// Only the five word addresses answer without an error.
	always_comb
	begin
		case (paddr)
			zcl_pkg::ADDR_CONTROL:
			begin
				mapped = 1'b1;
			end
			zcl_pkg::ADDR_STATUS:
			begin
				mapped = 1'b1;
			end
			zcl_pkg::ADDR_IRQ_EN:
			begin
				mapped = 1'b1;
			end
			zcl_pkg::ADDR_IRQ_CLR:
			begin
				mapped = 1'b1;
			end
			zcl_pkg::ADDR_SYSTEM:
			begin
				mapped = 1'b1;
			end
			default:
			begin
				mapped = 1'b0;
			end
		endcase
	end

	// Named views of the stored control and system bits.
	always_comb
	begin
		pol_bit = state.cross_control_reg[zcl_pkg::CTRL_POL_BIT];
		rise_en = state.cross_control_reg[zcl_pkg::CTRL_RISE_EN_BIT];
		fall_en = state.cross_control_reg[zcl_pkg::CTRL_FALL_EN_BIT];
		any_edge_en = rise_en || fall_en;
		line_en = state.irq_line_enable;
		group_en = state.system_bits[zcl_pkg::SYS_GROUP_BIT];
		global_en = state.system_bits[zcl_pkg::SYS_GLOBAL_BIT];
		levels_en = state.system_bits[zcl_pkg::SYS_LEVELS_BIT];
		prio_bit = state.system_bits[zcl_pkg::SYS_PRIO_BIT];
	end

	// The output path reads only the second sync flop, so a metastable first stage never reaches it.
	always_comb
	begin
		next_out = state.sync[1] ^ pol_bit;
	end

	// Both detectors compare the polarity-adjusted output with its value one cycle earlier.
	zcl_edge_detect
	#(
		.RISING (1'b1)
	)
	i_rise
	(
		.valid      (state.out_valid),
		.now_level  (next_out),
		.last_level (state.prev_out),
		.enable     (rise_en),
		.hit        (rise_hit)
	);

	zcl_edge_detect
	#(
		.RISING (1'b0)
	)
	i_fall
	(
		.valid      (state.out_valid),
		.now_level  (next_out),
		.last_level (state.prev_out),
		.enable     (fall_en),
		.hit        (fall_hit)
	);

	always_comb
	begin
		pol_change = wr_control &&
			(pwdata[zcl_pkg::CTRL_POL_BIT] != pol_bit);
		clr_flag = wr_clear && pwdata[zcl_pkg::STAT_FLAG_BIT];
		set_flag = rise_hit || fall_hit || pol_change;
		request = state.cross_irq_flag && line_en && group_en && global_en && any_edge_en;
		route_high = request && (!levels_en || prio_bit);
		route_low = request && levels_en && !prio_bit;
	end

	// All state moves through this one copy.
	always_comb
	begin
		next_state = state;

		next_state.sync = {state.sync[0], sink_active};
		next_state.cross_logic_out = next_out;
		next_state.prev_out = next_out;
		next_state.out_valid = 1'b1;

		// An edge or polarity change in the clearing cycle wins, so no event is lost.
		if (set_flag)
		begin
			next_state.cross_irq_flag = 1'b1;
		end
		else if (clr_flag)
		begin
			next_state.cross_irq_flag = 1'b0;
		end

		if (wr_strobe)
		begin
			case (paddr)
				zcl_pkg::ADDR_CONTROL:
				begin
					next_state.cross_control_reg = pwdata[3:0];
				end
				zcl_pkg::ADDR_IRQ_EN:
				begin
					next_state.irq_line_enable = pwdata[0];
				end
				zcl_pkg::ADDR_SYSTEM:
				begin
					next_state.system_bits = pwdata[4:0];
				end
				default:
				begin
					next_state.irq_line_enable = state.irq_line_enable;
				end
			endcase
		end

		next_state.irq_out = request;
		next_state.irq_high = route_high;
		next_state.irq_low = route_low;

		// The answer comes one cycle after setup, so every access phase lasts one cycle.
		next_state.pready = setup_cycle;
		next_state.pslverr = setup_cycle && !mapped;
		if (rd_strobe)
		begin
			case (paddr)
				zcl_pkg::ADDR_CONTROL:
				begin
					next_state.prdata = {28'h0000000, state.cross_control_reg};
				end
				zcl_pkg::ADDR_STATUS:
				begin
					next_state.prdata = {30'h00000000, state.cross_logic_out, state.cross_irq_flag};
				end
				zcl_pkg::ADDR_IRQ_EN:
				begin
					next_state.prdata = {31'h00000000, state.irq_line_enable};
				end
				zcl_pkg::ADDR_SYSTEM:
				begin
					next_state.prdata = {27'h0000000, state.system_bits};
				end
				default:
				begin
					next_state.prdata = 32'h00000000;
				end
			endcase
		end
		else if (setup_cycle)
		begin
			next_state.prdata = 32'h00000000;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			state <= '0;
		end
		else
		begin
			state <= next_state;
		end
	end

	// Every output is a bare flop of the state record.
	always_comb
	begin
		pready = state.pready;
		pslverr = state.pslverr;
		prdata = state.prdata;
		cross_logic_out = state.cross_logic_out;
		irq = state.irq_out;
		irq_high = state.irq_high;
		irq_low = state.irq_low;
	end

endmodule

// One edge detector; RISING picks the direction that it watches.
module zcl_edge_detect
#(
	parameter bit RISING = 1'b1
)
(
	input  wire logic valid,
	input  wire logic now_level,
	input  wire logic last_level,
	input  wire logic enable,
	output logic      hit
);

	logic moved_up;
	logic moved_down;

	always_comb
	begin
		moved_up = valid && now_level && !last_level;
		moved_down = valid && !now_level && last_level;
		if (RISING)
		begin
			hit = moved_up && enable;
		end
		else
		begin
			hit = moved_down && enable;
		end
	end

endmodule
